// File: shared/dx_params.svh
// Constants for the debug exit and program counter tracking block
`ifndef DX_PARAMS_SVH
`define DX_PARAMS_SVH
`define DX_SC1_LEN        33
`define DX_SYS_SPEED_BIT  32
`define DX_NOP_WORD       32'hE1A0_0000
`define DX_FETCH_MASK_CNT 2'h3
`define DX_ENTRY_ADV      6'h04
`define DX_SYS_ADV        6'h05
`define DX_ARM_ADDR_BYTES 4'h4
`define DX_CMP_ADDR_BYTES 4'h2
`define DX_IR_RESUME      4'h4
`define DX_IR_INTEST      4'hC
`endif

// File: shared/dx_pkg.sv
// Types shared by the debug exit block
package dx_pkg;
  typedef enum logic [2:0] {
    DX_ENT_NONE  = 3'b000,
    DX_ENT_BKPT  = 3'b001,
    DX_ENT_WATCH = 3'b010,
    DX_ENT_DREQ  = 3'b011,
    DX_ENT_WBKPT = 3'b100,
    DX_ENT_WEXC  = 3'b101
  } dx_entry_t;
  typedef enum logic [2:0] {
    DX_RUN     = 3'b000,
    DX_ENTER   = 3'b001,
    DX_DEBUG   = 3'b010,
    DX_SYSACC  = 3'b011,
    DX_ABORT   = 3'b100,
    DX_RESUME  = 3'b101,
    DX_MASKF   = 3'b110
  } dx_state_t;
endpackage

// File: core/dx_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ns
module dx_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: core/dx_scan_side.sv
// Scan chain 1 capture on the test clock, with resume event toggle
`timescale 1ns/1ns
`include "dx_params.svh"
module dx_scan_side (
  input  wire logic        tck,
  input  wire logic        trst,
  input  wire logic        tdi,
  input  wire logic        shift_dr,
  input  wire logic        update_dr,
  input  wire logic        run_idle,
  input  wire logic [3:0]  ir_code,
  input  wire logic        set_speed_lvl,
  output logic [32:0]      word_r,
  output logic             upd_tgl_r,
  output logic             resume_tgl_r
);
  logic [32:0] shreg_r;
  logic        idle_d_r;
  logic [2:0]  set_sync_r;
  wire         idle_rise = run_idle & ~idle_d_r;
  // MSB first: speed flag leads the instruction
  always_ff @(posedge tck or posedge trst) begin
    if (trst) begin
      shreg_r      <= '0;
      word_r       <= '0;
      upd_tgl_r    <= 1'b0;
      resume_tgl_r <= 1'b0;
      idle_d_r     <= 1'b0;
      set_sync_r   <= 3'b000;
    end else begin
      set_sync_r <= {set_sync_r[1:0], set_speed_lvl};
      idle_d_r   <= run_idle;
      if (shift_dr)
        shreg_r <= {shreg_r[31:0], tdi}; // [R20]
      if (update_dr) begin
        word_r    <= shreg_r;
        upd_tgl_r <= ~upd_tgl_r;
      end else if (set_sync_r[1] && !set_sync_r[2]) begin
        // One-shot: a held level would corrupt the flag of the next word
        word_r[`DX_SYS_SPEED_BIT] <= 1'b1; // [R22]
      end
      // Resume only on actual entry to idle, so chained cores restart together
      if (idle_rise && ir_code == `DX_IR_RESUME)
        resume_tgl_r <= ~resume_tgl_r; // [R3] [R4]
    end
  end
endmodule

// File: core/dx_debug_exit.sv
// Debug exit sequencing, acknowledge masking and program counter tracking
// Notes on behaviour
// (R1) Debugger scans return branch with flag clear
// (R2) Debugger scans closing no-op with flag set
// (R3) Resume instruction plus idle restarts core
// (R4) No restart before idle is entered
// (R5) Acknowledge high throughout debug state
// (R6) Pipeline flushed on entry, refilled on exit
// (R7) Acknowledge masks first three fetches after exit
// (R8) Fetch masking applies to breakpoint entry only
// (R9) Acknowledge stays high during system-speed access
// (R10) Breakpoint entry advances sixteen or eight bytes
// (R11) Each debug instruction adds one address
// (R12) Watchpoint entry adds four addresses
// (R13) Exception with watchpoint taken before debug
// (R14) Debugger checks modes and counter after watchpoint
// (R15) Watchpoint with breakpoint returns as breakpoint
// (R16) Debug request entry adds four addresses
// (R17) System-speed access adds five addresses
// (R18) Aborted system access enters abort mode first
// (R19) Debugger branch offset is minus four plus N plus five S
// (R20) Chain shifted MSB first, flag leading
// (R21) Debugger removes breakpoint then branches back
// (R22) Flag left set after system-speed return
// (R23) Flag is bit 33 and selects clock
`timescale 1ns/1ns
`include "dx_params.svh"
module dx_debug_exit (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tck,
  input  wire logic              trst,
  input  wire logic              tdi,
  input  wire logic              shift_dr,
  input  wire logic              update_dr,
  input  wire logic              run_idle,
  input  wire logic [3:0]        ir_code,
  input  wire dx_pkg::dx_entry_t entry_kind,
  input  wire logic              entry_req,
  input  wire logic              compressed_mode,
  input  wire logic              exc_pending,
  input  wire logic              fetch_strobe,
  input  wire logic              sys_done,
  input  wire logic              sys_abort,
  output logic                   debug_acknowledge,
  output logic                   in_debug,
  output logic                   pipe_flush,
  output logic                   fetch_enable,
  output logic                   scan_system_mode,
  output logic                   debug_internal_clock_sel,
  output logic                   abort_mode,
  output logic                   exc_vector_fetch,
  output logic [31:0]            pc_offset,
  output logic [31:0]            insn_word,
  output logic                   insn_valid,
  output logic                   system_speed_flag
);
  import dx_pkg::*;

  dx_state_t   state_r;
  dx_state_t   state_nxt;
  dx_entry_t   kind_r;
  logic [1:0]  mask_cnt_r;
  logic [31:0] pc_off_r;
  logic [2:0]  upd_sync_r;
  logic [2:0]  res_sync_r;
  logic        set_flag_lvl_r;
  logic [32:0] word_tck;
  logic [32:0] word_sync;
  logic        upd_tgl_tck;
  logic        res_tgl_tck;
  logic        upd_tgl_s;
  logic        res_tgl_s;
  logic        insn_valid_r;
  logic        last_sys_r;
  logic        flush_r;
  logic        vec_r;

  // Scan side on the test clock
  dx_scan_side u_scan (
    .tck           (tck),
    .trst          (trst),
    .tdi           (tdi),
    .shift_dr      (shift_dr),
    .update_dr     (update_dr),
    .run_idle      (run_idle),
    .ir_code       (ir_code),
    .set_speed_lvl (set_flag_lvl_r),
    .word_r        (word_tck),
    .upd_tgl_r     (upd_tgl_tck),
    .resume_tgl_r  (res_tgl_tck)
  );

  // Event toggles cross as levels through two flip-flops
  dx_sync2 #(.W(2)) u_tgl_sync (
    .clk (clk),
    .rst (rst),
    .d   ({upd_tgl_tck, res_tgl_tck}),
    .q   ({upd_tgl_s, res_tgl_s})
  );

  // Edge detection on synchronised toggles
  wire upd_ev    = upd_tgl_s ^ upd_sync_r[0];
  wire resume_ev = res_tgl_s ^ res_sync_r[0];

  // The word is not synchronised bit by bit: it stays still from its update
  // until long after its toggle lands, so it is sampled only in the event cycle.
  // This keeps bits of two different words from mixing on the way across.
  wire [32:0] word_now = upd_ev ? word_tck : word_sync;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      word_sync <= '0;
    else if (upd_ev)
      word_sync <= word_tck;
  end
  wire sys_flag  = word_now[`DX_SYS_SPEED_BIT]; // [R23]
  wire bkpt_like = (kind_r == DX_ENT_BKPT) || (kind_r == DX_ENT_WBKPT);

  // Entry advance: four addresses for every documented entry kind
  wire [31:0] entry_adv = {26'h000_0000, `DX_ENTRY_ADV}; // [R10] [R12] [R16]
  wire [31:0] sys_adv   = {26'h000_0000, `DX_SYS_ADV};

  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DX_RUN:
        if (entry_req)
          state_nxt = (entry_kind == DX_ENT_WEXC) ? DX_ABORT : DX_ENTER;
      DX_ABORT:
        state_nxt = DX_ENTER; // [R13] [R18]
      DX_ENTER:
        state_nxt = DX_DEBUG;
      DX_DEBUG:
        if (resume_ev && sys_flag && last_sys_r)
          state_nxt = DX_SYSACC; // [R9]
        else if (resume_ev && sys_flag)
          state_nxt = DX_RESUME; // [R3] [R4]
      DX_SYSACC:
        if (sys_abort)
          state_nxt = DX_ABORT; // [R18]
        else if (sys_done)
          state_nxt = DX_DEBUG;
      DX_RESUME:
        state_nxt = bkpt_like ? DX_MASKF : DX_RUN; // [R8]
      DX_MASKF:
        if (fetch_strobe && mask_cnt_r == 2'h1)
          state_nxt = DX_RUN; // [R7]
      default:
        state_nxt = DX_RUN;
    endcase
  end

  // State, entry kind, crossing history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= DX_RUN;
      kind_r     <= DX_ENT_NONE;
      upd_sync_r <= 3'h0;
      res_sync_r <= 3'h0;
    end else begin
      state_r    <= state_nxt;
      upd_sync_r <= {upd_sync_r[1:0], upd_tgl_s};
      res_sync_r <= {res_sync_r[1:0], res_tgl_s};
      if (state_r == DX_RUN && entry_req)
        kind_r <= (entry_kind == DX_ENT_WEXC) ? DX_ENT_WATCH : entry_kind; // [R15]
    end
  end

  // Program counter offset tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_off_r   <= 32'h0000_0000;
      last_sys_r <= 1'b0;
    end else if (state_r == DX_ENTER) begin
      pc_off_r   <= entry_adv; // [R10] [R12] [R16]
      last_sys_r <= 1'b0;
    end else if (state_r == DX_DEBUG && upd_ev) begin
      // Flag of the word before this one: two flag words in a row mean system access
      last_sys_r <= word_sync[`DX_SYS_SPEED_BIT];
      if (!sys_flag)
        pc_off_r <= pc_off_r + 32'h0000_0001; // [R11]
    end else if (state_r == DX_SYSACC && (sys_done || sys_abort)) begin
      pc_off_r <= pc_off_r + sys_adv; // [R17]
    end
  end

  // Fetch mask counter after breakpoint exit
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      mask_cnt_r <= 2'h0;
    else if (state_r == DX_RESUME)
      mask_cnt_r <= `DX_FETCH_MASK_CNT; // [R7]
    else if (state_r == DX_MASKF && fetch_strobe && mask_cnt_r != 2'h0)
      mask_cnt_r <= mask_cnt_r - 2'h1;
  end

  // Registered outputs
  wire dbg_st  = (state_r == DX_ENTER) || (state_r == DX_DEBUG) || (state_r == DX_ABORT);
  wire ack_nxt = (state_nxt != DX_RUN); // [R5] [R7] [R9]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_acknowledge        <= 1'b0;
      in_debug                 <= 1'b0;
      flush_r                  <= 1'b0;
      fetch_enable             <= 1'b1;
      scan_system_mode         <= 1'b1;
      debug_internal_clock_sel <= 1'b0;
      abort_mode               <= 1'b0;
      vec_r                    <= 1'b0;
      pc_offset                <= 32'h0000_0000;
      insn_word                <= 32'h0000_0000;
      insn_valid_r             <= 1'b0;
      system_speed_flag        <= 1'b0;
      set_flag_lvl_r           <= 1'b0;
    end else begin
      debug_acknowledge        <= ack_nxt; // [R5]
      in_debug                 <= (state_nxt == DX_DEBUG) || (state_nxt == DX_ENTER);
      flush_r                  <= (state_nxt == DX_ENTER); // [R6]
      fetch_enable             <= !((state_nxt == DX_ENTER) || (state_nxt == DX_DEBUG));
      scan_system_mode         <= !dbg_st || (state_nxt == DX_RUN); // [R3]
      debug_internal_clock_sel <= (state_nxt == DX_DEBUG) || (state_nxt == DX_ENTER);
      abort_mode               <= (state_nxt == DX_ABORT) ? 1'b1 :
                                  (state_nxt == DX_RUN) ? 1'b0 : abort_mode; // [R18]
      vec_r                    <= (state_nxt == DX_ABORT); // [R13]
      pc_offset                <= pc_off_r;
      insn_word                <= word_sync[31:0];
      insn_valid_r             <= (state_r == DX_DEBUG) && upd_ev;
      system_speed_flag        <= sys_flag;
      // Return from system access leaves the flag high in the chain
      set_flag_lvl_r           <= (state_r == DX_SYSACC) && (sys_done || sys_abort) ? 1'b1 :
                                  (state_r == DX_DEBUG && upd_ev) ? 1'b0 : set_flag_lvl_r; // [R22]
    end
  end
  assign pipe_flush       = flush_r;
  assign exc_vector_fetch = vec_r;
  assign insn_valid       = insn_valid_r;

  // Checks
  a_ack_in_debug: assert property (@(posedge clk) disable iff (rst) // [R5]
    (state_r == DX_DEBUG || state_r == DX_ENTER) |-> debug_acknowledge && in_debug)
    else $error("ack low in debug");
  a_run_ack: assert property (@(posedge clk) disable iff (rst) // [R5]
    (state_r == DX_RUN && !entry_req) |=> !debug_acknowledge)
    else $error("ack high while running");
  a_no_early_resume: assert property (@(posedge clk) disable iff (rst) // [R4]
    (state_r == DX_DEBUG && !resume_ev) |=> state_r != DX_RESUME) else $error("early resume");
  a_resume_exit: assert property (@(posedge clk) disable iff (rst) // [R3]
    (state_r == DX_RESUME) |-> ##2 scan_system_mode) else $error("scan not system");
  a_flush_entry: assert property (@(posedge clk) disable iff (rst) // [R6]
    (state_r == DX_ENTER) |-> pipe_flush) else $error("no flush");
  a_entry_adv: assert property (@(posedge clk) disable iff (rst) // [R10]
    (state_r == DX_ENTER) |=> pc_off_r == 32'h0000_0004) else $error("entry advance");
  a_debug_step: assert property (@(posedge clk) disable iff (rst) // [R11]
    (state_r == DX_DEBUG && upd_ev && !sys_flag) |=> pc_off_r == $past(pc_off_r) + 32'h1)
    else $error("debug step");
  a_sys_step: assert property (@(posedge clk) disable iff (rst) // [R17]
    (state_r == DX_SYSACC && sys_done && !sys_abort) |=> pc_off_r == $past(pc_off_r) + 32'h5)
    else $error("sys step");
  a_sys_ack: assert property (@(posedge clk) disable iff (rst) // [R9]
    (state_r == DX_SYSACC) |-> debug_acknowledge) else $error("sys ack low");
  a_mask_ack: assert property (@(posedge clk) disable iff (rst) // [R7]
    (state_r == DX_MASKF) |-> debug_acknowledge) else $error("mask ack low");
  a_watch_nomask: assert property (@(posedge clk) disable iff (rst) // [R8]
    (state_r == DX_RESUME && kind_r == DX_ENT_WATCH) |=> state_r == DX_RUN)
    else $error("watch masked");
  a_abort_first: assert property (@(posedge clk) disable iff (rst) // [R18]
    (state_r == DX_SYSACC && sys_abort) |=> state_r == DX_ABORT ##1 state_r == DX_ENTER)
    else $error("abort order");
  a_abort_mode: assert property (@(posedge clk) disable iff (rst) // [R18]
    (state_r == DX_ABORT) |-> abort_mode) else $error("abort mode low");
  // Entry and exception ordering
  a_wexc_abort: assert property (@(posedge clk) disable iff (rst) // [R13]
    (state_r == DX_RUN && entry_req && entry_kind == DX_ENT_WEXC) |=>
    state_r == DX_ABORT && exc_vector_fetch && abort_mode ##1 state_r == DX_ENTER)
    else $error("exception not taken first");
  a_debug_fetch: assert property (@(posedge clk) disable iff (rst) // [R6]
    (state_r == DX_DEBUG) |-> !fetch_enable && debug_internal_clock_sel)
    else $error("fetching in debug");
  // Fetch masking after a breakpoint
  a_mask_count: assert property (@(posedge clk) disable iff (rst) // [R7]
    (state_r == DX_RESUME && bkpt_like) |=> state_r == DX_MASKF && mask_cnt_r == 2'h3)
    else $error("mask count");
  a_fetch_ack: assert property (@(posedge clk) disable iff (rst) // [R7]
    (state_r == DX_MASKF && fetch_strobe && mask_cnt_r == 2'h1) |=>
    state_r == DX_RUN && !debug_acknowledge) else $error("ack after third fetch");
  a_exit_scan: assert property (@(posedge clk) disable iff (rst) // [R3]
    (state_r == DX_MASKF) |-> scan_system_mode && fetch_enable) else $error("exit mode");
  a_resume_clk: assert property (@(posedge clk) disable iff (rst) // [R3]
    (state_r == DX_RESUME) |-> !debug_internal_clock_sel) else $error("clock not back");
  // System-speed access
  a_sys_enter: assert property (@(posedge clk) disable iff (rst) // [R9]
    (state_r == DX_DEBUG && resume_ev && sys_flag && last_sys_r) |=>
    state_r == DX_SYSACC && debug_acknowledge) else $error("system access entry");
  a_flag_left: assert property (@(posedge clk) disable iff (rst) // [R22]
    (state_r == DX_SYSACC && (sys_done || sys_abort)) |=> set_flag_lvl_r)
    else $error("flag not left set");
  c_bkpt_exit: cover property (@(posedge clk) disable iff (rst)
    state_r == DX_MASKF ##1 state_r == DX_RUN);
  c_sys_access: cover property (@(posedge clk) disable iff (rst)
    state_r == DX_SYSACC ##1 state_r == DX_DEBUG);
  c_watch_exc: cover property (@(posedge clk) disable iff (rst)
    state_r == DX_ABORT ##1 state_r == DX_ENTER);
  c_dreq_exit: cover property (@(posedge clk) disable iff (rst)
    state_r == DX_RESUME && kind_r == DX_ENT_DREQ ##1 state_r == DX_RUN);
  c_sys_abort: cover property (@(posedge clk) disable iff (rst)
    state_r == DX_SYSACC && sys_abort);
endmodule

// File: dv/dx_jtag_host.sv
// Behavioural debugger that drives the test access port
`timescale 1ns/1ns
`include "dx_params.svh"
module dx_jtag_host (
  output logic       tck,
  output logic       trst,
  output logic       tdi,
  output logic       shift_dr,
  output logic       update_dr,
  output logic       run_idle,
  output logic [3:0] ir_code
);
  // Test clock runs only inside frames, low between them
  task automatic tick(input int n);
    repeat (n) begin
      #8 tck = 1'b1;
      #7 tck = 1'b0;
    end
  endtask
  // Flag bit first, then the instruction, then latch
  task automatic scan(input logic [32:0] w);
    ir_code = `DX_IR_INTEST;
    shift_dr = 1'b1;
    for (int i = 32; i >= 0; i--) begin
      tdi = w[i];
      tick(1);
    end
    shift_dr = 1'b0;
    tdi = ~tdi; // Released line must not keep the last bit
    update_dr = 1'b1;
    tick(1);
    update_dr = 1'b0;
    tick(2);
  endtask
  // Resume picked first, idle entered later, so restarts can be staged
  task automatic sel_resume();
    ir_code = `DX_IR_RESUME;
    tick(2);
  endtask
  task automatic idle();
    run_idle = 1'b1;
    tick(3);
    run_idle = 1'b0;
    ir_code = `DX_IR_INTEST;
    tick(1);
  endtask
  // Test logic reset with a few clocks
  initial begin
    {tck, tdi, shift_dr, update_dr, run_idle} = '0;
    ir_code = `DX_IR_INTEST;
    trst = 1'b1;
    tick(4);
    trst = 1'b0;
  end
endmodule

// File: dv/dx_debug_exit_tb.sv
// Self-checking bench for the debug exit block
`timescale 1ns/1ns
`include "dx_params.svh"
module dx_debug_exit_tb;
  import dx_pkg::*;
  logic        clk, rst, tck, trst, tdi, shift_dr, update_dr, run_idle;
  logic [3:0]  ir_code;
  dx_entry_t   entry_kind;
  logic        entry_req, compressed_mode, exc_pending, fetch_strobe, sys_done, sys_abort;
  logic        debug_acknowledge, in_debug, pipe_flush, fetch_enable, scan_system_mode;
  logic        abort_mode, exc_vector_fetch, insn_valid, system_speed_flag;
  logic        debug_internal_clock_sel, valid_seen;
  logic [31:0] pc_offset, insn_word;
  logic        flush_seen, abort_seen, exc_seen;
  int          failures, n_checks, cyc;

  dx_jtag_host host (.tck(tck), .trst(trst), .tdi(tdi), .shift_dr(shift_dr),
    .update_dr(update_dr), .run_idle(run_idle), .ir_code(ir_code));
  dx_debug_exit dut (.clk(clk), .rst(rst), .tck(tck), .trst(trst), .tdi(tdi),
    .shift_dr(shift_dr), .update_dr(update_dr), .run_idle(run_idle), .ir_code(ir_code),
    .entry_kind(entry_kind), .entry_req(entry_req), .compressed_mode(compressed_mode),
    .exc_pending(exc_pending), .fetch_strobe(fetch_strobe), .sys_done(sys_done),
    .sys_abort(sys_abort), .debug_acknowledge(debug_acknowledge), .in_debug(in_debug),
    .pipe_flush(pipe_flush), .fetch_enable(fetch_enable),
    .scan_system_mode(scan_system_mode), .debug_internal_clock_sel(debug_internal_clock_sel),
    .abort_mode(abort_mode), .exc_vector_fetch(exc_vector_fetch), .pc_offset(pc_offset),
    .insn_word(insn_word), .insn_valid(insn_valid), .system_speed_flag(system_speed_flag));

  always #25 clk = ~clk;
  // Short pulses are latched so a later check cannot miss them
  always @(posedge clk) begin
    if (pipe_flush === 1'b1) flush_seen <= 1'b1;
    if (abort_mode === 1'b1) abort_seen <= 1'b1;
    if (exc_vector_fetch === 1'b1) exc_seen <= 1'b1;
    if (insn_valid === 1'b1) valid_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // Leaves the bench just after an edge, the phase every driver relies on
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc_wait(1);
    s = 1'b0;
    cyc_wait(1);
  endtask
  task automatic enter(input dx_entry_t k);
    {flush_seen, abort_seen, exc_seen, valid_seen} = '0;
    entry_kind = k;
    pulse(entry_req);
    cyc_wait(12);
  endtask
  task automatic resume();
    host.sel_resume();
    host.idle();
    cyc_wait(8);
  endtask
  task automatic exit_seq(input logic [31:0] br);
    host.scan({1'b0, br});
    host.scan({1'b1, `DX_NOP_WORD});
    resume();
  endtask
  // Two flag words in a row start a memory access from debug
  task automatic sys_acc();
    host.scan({1'b1, 32'hE591_0000});
    host.scan({1'b1, `DX_NOP_WORD});
    resume();
  endtask

  task automatic t_bkpt();
    compressed_mode = 1'b1;
    enter(DX_ENT_BKPT);
    chk(flush_seen === 1'b1, "no flush on entry");
    chk(debug_acknowledge === 1'b1, "ack low in debug");
    chk(pc_offset === 32'h0000_0004, "breakpoint entry offset");
    chk(debug_internal_clock_sel === 1'b1, "not on debug clock");
    host.scan({1'b0, 32'hEAFF_FFF9});
    cyc_wait(10);
    chk(valid_seen === 1'b1 && insn_word === 32'hEAFF_FFF9, "scanned word");
    chk(pc_offset === 32'h0000_0005, "debug insn offset");
    host.scan({1'b1, `DX_NOP_WORD});
    host.sel_resume();
    cyc_wait(10);
    chk(in_debug === 1'b1, "left debug before idle");
    host.idle();
    cyc_wait(6);
    chk(scan_system_mode === 1'b1 && fetch_enable === 1'b1, "no restart");
    chk(debug_internal_clock_sel === 1'b0, "still on debug clock");
    pulse(fetch_strobe);
    pulse(fetch_strobe);
    chk(debug_acknowledge === 1'b1, "ack dropped early");
    pulse(fetch_strobe);
    cyc_wait(2);
    chk(debug_acknowledge === 1'b0, "ack held after three fetches");
  endtask
  task automatic t_dreq();
    enter(DX_ENT_DREQ);
    chk(pc_offset === 32'h0000_0004, "request entry offset");
    exit_seq(32'hEAFF_FFFD);
    chk(debug_acknowledge === 1'b0, "fetches masked after request");
  endtask
  task automatic t_wbkpt();
    enter(DX_ENT_WBKPT);
    chk(pc_offset === 32'h0000_0004, "watch and break entry offset");
    exit_seq(32'hEAFF_FFFD);
    chk(debug_acknowledge === 1'b1, "watch and break not masked");
    repeat (3) pulse(fetch_strobe);
    cyc_wait(2);
    chk(debug_acknowledge === 1'b0, "ack held after fetches");
  endtask
  task automatic t_watch_sys();
    enter(DX_ENT_WATCH);
    chk(pc_offset === 32'h0000_0004, "watch entry offset");
    sys_acc();
    chk(debug_acknowledge === 1'b1, "ack low in system access");
    pulse(sys_done);
    cyc_wait(4);
    chk(in_debug === 1'b1 && pc_offset === 32'h0000_0009, "system access offset");
    chk(system_speed_flag === 1'b1, "speed flag not left set");
    sys_acc();
    pulse(sys_abort);
    cyc_wait(6);
    chk(abort_seen === 1'b1 && in_debug === 1'b1, "aborted access");
    exit_seq(32'hEAFF_FFF0);
  endtask
  task automatic t_wexc();
    enter(DX_ENT_WEXC);
    chk(abort_seen === 1'b1 && exc_seen === 1'b1, "no vector fetch");
    chk(in_debug === 1'b1, "not in debug after exception");
    chk(abort_mode === 1'b1, "exception mode not visible");
    exit_seq(32'hEAFF_FFFC);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    entry_kind = DX_ENT_NONE;
    {entry_req, compressed_mode, exc_pending, fetch_strobe, sys_done, sys_abort} = '0;
    {flush_seen, abort_seen, exc_seen, valid_seen} = '0;
    failures = 0;
    n_checks = 0;
    cyc = 0;
    cyc_wait(9);
    chk(debug_acknowledge === 1'b0 && fetch_enable === 1'b1, "reset outputs");
    chk(scan_system_mode === 1'b1 && in_debug === 1'b0, "reset mode");
    cyc_wait(1);
    rst = 1'b0;
    cyc_wait(3);
    t_bkpt();
    t_dreq();
    t_watch_sys();
    t_wexc();
    t_wbkpt();
    print_verdict();
  end
endmodule
